// file: cpu_status_fetch.v
// cpu status word, bank select, fetch source, mux port, reset sync
// assumes apb master on pclk; pins asynchronous to pclk
//
// Function
// [RULE_01] with fetch select high, pc below the limit fetches internally.
// [RULE_02] with fetch select low, every fetch is external.
// [RULE_03] the mux port is 8-bit open drain; a latched one floats.
// [RULE_04] during external accesses the port drives address then data.
// [RULE_05] verify mode puts code bytes on the port; verifier pulls up.
// [RULE_06] carry, overflow and half carry are updated by arithmetic.
// [RULE_07] the two bank bits pick one of four 8-byte register banks.
// [RULE_08] parity follows odd one-count of the accumulator each step.
// [RULE_09] the active-high reset pin is synchronised before use.
// [RULE_10] the reset source holds reset for 12 oscillator periods.
// [RULE_11] 256 bytes of data memory, the low 32 hold the banks.
// [RULE_12] the sfr space spans 128 bytes apart from data memory.
// [RULE_13] program space is 64 kbyte behind a 16-bit pc.
// [RULE_14] the two spare flags are software only.
// [RULE_15] the status word resets to zero.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_defines.vh"
module cpu_status_fetch
#(
   parameter        LARGE_VARIANT = 0
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        fetch_source_select,
   input  wire        reset_pin,
   input  wire [7:0]  mux_port_pins_in,
   output reg  [7:0]  mux_port_pins_out,
   output reg  [7:0]  mux_port_pins_oe_n,
   output reg         fetch_internal,
   output reg  [4:0]  bank_base,
   output reg         core_reset
);
// ------------------------------------------------------------
// synchronisers
// ------------------------------------------------------------
reg        rst_s1;
reg        rst_s2;
reg        ea_s1;
reg        ea_s2;
reg [7:0]  pin_s1;
reg [7:0]  pin_s2;
reg [3:0]  rst_cnt;
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      ea_s1  <= 1'b0;
      ea_s2  <= 1'b0;
      pin_s1 <= 8'hFF;
      pin_s2 <= 8'hFF;
   end
   else if (clk_en)
   begin
      rst_s1 <= reset_pin; // [RULE_09]
      rst_s2 <= rst_s1;
      ea_s1  <= fetch_source_select;
      ea_s2  <= ea_s1;
      pin_s1 <= mux_port_pins_in;
      pin_s2 <= pin_s1;
   end
end
// ------------------------------------------------------------
// state
// ------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_ADDR = 4'h2;
localparam [3:0] ST_DATA = 4'h4;
localparam [3:0] ST_DONE = 4'h8;
wire        acc_en   = psel & penable & ~pready;
wire        wr       = acc_en & pwrite;
wire        hit_sw   = (paddr == `OFS_STATUS_WORD);
wire        hit_acc  = (paddr == `OFS_ACCUM);
wire        hit_fc   = (paddr == `OFS_FETCH_CTRL);
wire        hit_fs   = (paddr == `OFS_FETCH_STAT);
wire        hit_bc   = (paddr == `OFS_BUS_CTRL);
wire        hit_bd   = (paddr == `OFS_BUS_DATA);
wire        hit_pl   = (paddr == `OFS_PORT_LATCH);
wire        hit_pi   = (paddr == `OFS_PORT_IN);
wire        hit_pc   = (paddr == `OFS_PC);
wire        hit_rs   = (paddr == `OFS_RESET_STAT);
wire        hit_dp   = (paddr == `OFS_DATA_PTR);
wire        hit_dv   = (paddr == `OFS_DATA_VAL);
// sfr decode, kept apart from the data memory array
wire        mapped   = hit_sw | hit_acc | hit_fc | hit_fs | hit_bc |
                       hit_bd | hit_pl | hit_pi | hit_pc | hit_rs |
                       hit_dp | hit_dv; // [RULE_12]
reg  [7:0]  status_word;
reg  [7:0]  accum;
reg  [15:0] pc;
reg  [7:0]  port_latch;
reg  [7:0]  bus_data;
reg  [7:0]  bus_ctrl;
reg  [3:0]  bus_state;
reg         rst_seen;
reg  [7:0]  data_ptr;
reg  [1:0]  data_wait;
// 256 bytes, the low 32 hold the four register banks
reg  [7:0]  data_mem [0:`DATA_MEM_DEPTH-1]; // [RULE_11]
wire [15:0] limit = LARGE_VARIANT ? `LIMIT_LARGE : `LIMIT_SMALL;
// [RULE_13] a 16-bit pc bounds program space to 64 kbyte
wire        next_internal = ea_s2 & (pc < limit); // [RULE_01] [RULE_02]
wire        busy = (bus_state != ST_IDLE);
// arithmetic step: software writes operand to fetch_ctrl[15:8] and adds
wire [7:0]  opnd = pwdata[15:8];
wire [8:0]  sum  = {1'b0, accum} + {1'b0, opnd};
wire [4:0]  hsum = {1'b0, accum[3:0]} + {1'b0, opnd[3:0]};
wire        wrap = (accum[7] == opnd[7]) & (sum[7] != accum[7]);
wire        do_add = wr & hit_fc & pwdata[0];
wire [7:0]  next_acc = do_add ? sum[7:0] :
                       (wr & hit_acc) ? pwdata[7:0] : accum;
// ------------------------------------------------------------
// internal data memory
// ------------------------------------------------------------
// no reset on the array: contents are unknown until written
always @(posedge pclk)
begin
   if (clk_en & wr & hit_dv & ~core_reset)
      data_mem[data_ptr] <= pwdata[7:0]; // [RULE_11]
end
// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      status_word <= `SW_RESET; // [RULE_15]
      accum       <= 8'h00;
      pc          <= 16'h0000;
      port_latch  <= 8'hFF;
      bus_data    <= 8'h00;
      bus_ctrl    <= 8'h00;
      bus_state   <= ST_IDLE;
      rst_seen    <= 1'b0;
      data_ptr    <= 8'h00;
      data_wait   <= 2'h0;
      rst_cnt     <= 4'h0;
      core_reset  <= 1'b1;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
   end
   else if (clk_en)
   begin
      // reset counts the pin's high time; short pulses are ignored
      if (rst_s2)
      begin
         if (rst_cnt != 4'hF)
            rst_cnt <= rst_cnt + 4'h1;
         if (rst_cnt >= (`RESET_MIN_OSC - 1))
            core_reset <= 1'b1; // [RULE_09] [RULE_10]
      end
      else
      begin
         rst_cnt    <= 4'h0;
         core_reset <= 1'b0;
      end
      if (core_reset)
      begin
         status_word <= `SW_RESET; // [RULE_15]
         accum       <= 8'h00;
         pc          <= 16'h0000;
         rst_seen    <= 1'b1;
      end
      else
      begin
         accum <= next_acc;
         if (wr & hit_sw)
            status_word[7:1] <= pwdata[7:1]; // [RULE_14] [RULE_07]
         if (do_add)
         begin
            status_word[`SW_CARRY]      <= sum[8];   // [RULE_06]
            status_word[`SW_HALF_CARRY] <= hsum[4];  // [RULE_06]
            status_word[`SW_WRAP]       <= wrap;     // [RULE_06]
         end
         status_word[`SW_PARITY] <= ^next_acc; // [RULE_08]
         if (wr & hit_pc)
            pc <= pwdata[15:0];
         if (wr & hit_pl)
            port_latch <= pwdata[7:0]; // [RULE_03]
         if (wr & hit_bd)
            bus_data <= pwdata[7:0];
         if (wr & hit_dp)
            data_ptr <= pwdata[7:0];
         if (wr & hit_rs)
            rst_seen <= rst_seen & ~pwdata[0];
      end
      // external access sequencer: address byte, then data
      case (bus_state)
         ST_IDLE:
         begin
            if (wr & hit_bc & pwdata[`BC_START])
            begin
               bus_ctrl  <= pwdata[7:0];
               bus_state <= ST_ADDR;
            end
         end
         ST_ADDR:
            bus_state <= ST_DATA;
         ST_DATA:
         begin
            // synchronised pins lag the bus: wait out the two flops
            if (data_wait == `BUS_DATA_WAIT)
            begin
               if (!bus_ctrl[`BC_WRITE])
                  bus_data <= pin_s2; // [RULE_04]
               data_wait <= 2'h0;
               bus_state <= ST_DONE;
            end
            else
               data_wait <= data_wait + 2'h1;
         end
         ST_DONE:
         begin
            if (!bus_ctrl[`BC_DATA_SPACE])
               pc <= pc + 16'h0001;
            bus_state <= ST_IDLE;
         end
         default:
            bus_state <= ST_IDLE;
      endcase
      // apb slave: one wait state, unmapped reads zero with error
      pready  <= acc_en;
      pslverr <= acc_en & ~mapped;
      if (acc_en & ~pwrite)
      begin
         prdata <= 32'h0000_0000;
         if (hit_sw)
            prdata[7:0] <= status_word;
         if (hit_acc)
            prdata[7:0] <= accum;
         if (hit_fs)
            prdata[3:0] <= {busy, fetch_internal, ea_s2, 1'b0};
         if (hit_bc)
            prdata[7:0] <= bus_ctrl;
         if (hit_bd)
            prdata[7:0] <= bus_data;
         if (hit_pl)
            prdata[7:0] <= port_latch;
         if (hit_pi)
            prdata[7:0] <= pin_s2;
         if (hit_pc)
            prdata[15:0] <= pc;
         if (hit_rs)
            prdata[1:0] <= {core_reset, rst_seen};
         if (hit_dp)
            prdata[7:0] <= data_ptr;
         if (hit_dv)
            prdata[7:0] <= data_mem[data_ptr]; // [RULE_11]
      end
      else if (!acc_en)
         prdata <= 32'h0000_0000;
   end
end
// ------------------------------------------------------------
// pin drive
// ------------------------------------------------------------
// address phases and data writes drive ones hard; otherwise open drain only pulls low
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      mux_port_pins_out  <= 8'hFF;
      mux_port_pins_oe_n <= 8'hFF;
      fetch_internal     <= 1'b0;
      bank_base          <= 5'h00;
   end
   else if (clk_en)
   begin
      fetch_internal <= next_internal;
      bank_base <= {status_word[`SW_BANK_HIGH],
                    status_word[`SW_BANK_LOW], 3'b000}; // [RULE_07] [RULE_11]
      if (bus_state == ST_ADDR)
      begin
         mux_port_pins_out  <= pc[7:0];  // [RULE_04]
         mux_port_pins_oe_n <= 8'h00;
      end
      else if ((bus_state == ST_DATA) & bus_ctrl[`BC_WRITE])
      begin
         mux_port_pins_out  <= bus_data; // [RULE_04]
         mux_port_pins_oe_n <= 8'h00;
      end
      else if ((bus_state == ST_DATA) & bus_ctrl[`BC_VERIFY])
      begin
         // code byte is open drain; verifier supplies pullups
         mux_port_pins_out  <= 8'h00;
         mux_port_pins_oe_n <= bus_data; // [RULE_05]
      end
      else
      begin
         mux_port_pins_out  <= 8'h00;
         mux_port_pins_oe_n <= port_latch; // [RULE_03]
      end
   end
end
endmodule
`default_nettype wire

// file: cpu_status_defines.vh
// constants for the cpu status word and fetch-select block
// assumes plain verilog-2005 inclusion by bare name
`ifndef CPU_STATUS_DEFINES_VH
`define CPU_STATUS_DEFINES_VH
// ------------------------------------------------------------
// register offsets (byte addresses on apb)
// ------------------------------------------------------------
`define OFS_STATUS_WORD   8'hD0
`define OFS_ACCUM         8'hE0
`define OFS_FETCH_CTRL    8'h00
`define OFS_FETCH_STAT    8'h04
`define OFS_BUS_CTRL      8'h08
`define OFS_BUS_DATA      8'h0C
`define OFS_PORT_LATCH    8'h10
`define OFS_PORT_IN       8'h14
`define OFS_PC            8'h18
`define OFS_RESET_STAT    8'h1C
`define OFS_DATA_PTR      8'h24
`define OFS_DATA_VAL      8'h28
// ------------------------------------------------------------
// status word field positions
// ------------------------------------------------------------
`define SW_CARRY          7
`define SW_HALF_CARRY     6
`define SW_SPARE0         5
`define SW_BANK_HIGH      4
`define SW_BANK_LOW       3
`define SW_WRAP           2
`define SW_SPARE1         1
`define SW_PARITY         0
`define SW_RESET          8'h00
// ------------------------------------------------------------
// bus control fields
// ------------------------------------------------------------
`define BC_START          0
`define BC_DATA_SPACE     1
`define BC_WRITE          2
`define BC_VERIFY         3
// ------------------------------------------------------------
// memory sizing
// ------------------------------------------------------------
`define LIMIT_SMALL       16'h4000
`define LIMIT_LARGE       16'h8000
`define DATA_MEM_DEPTH    256
`define SFR_SPAN          128
`define BANK_SPAN         8'h20
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OSC_PER_MACHINE   6
`define RESET_MIN_MACH    2
`define RESET_MIN_OSC     (`OSC_PER_MACHINE * `RESET_MIN_MACH)
`define BUS_DATA_WAIT     2'h3
`endif

// file: cpu_status_chk.sv
// checker bound to the status word and fetch select block
// assumes one clock domain, pclk, with presetn as its reset
`timescale 1ns/1ps
`default_nettype none
module cpu_status_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fetch_source_select,
   input wire logic        reset_pin,
   input wire logic [7:0]  mux_port_pins_oe_n,
   input wire logic        fetch_internal,
   input wire logic [4:0]  bank_base,
   input wire logic        core_reset
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // last high run of the pin, kept while low: the core_reset rise lags the pin
   logic [4:0] run;
   logic       pin_d;
   logic [1:0] bank_wr;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run     <= 5'h00;
         pin_d   <= 1'b0;
         bank_wr <= 2'h0;
      end
      else
      begin
         pin_d   <= reset_pin;
         bank_wr <= pwdata[4:3];
         if (reset_pin)
            run <= pin_d ? run + {4'h0, run != 5'h1F} : 5'h01;
      end
   end
   AST_BANK_ALIGN:
      assert property (pready && pwrite && paddr == 8'hD0 && !core_reset
         |=> bank_base == {bank_wr, 3'b000})
      else $error("bank base misaligned");
   AST_EXT_FETCH:
      assert property ((!fetch_source_select)[*8] |-> !fetch_internal)
      else $error("internal fetch with select low");
   AST_RST_DROP:
      assert property ((!reset_pin)[*6] |-> !core_reset)
      else $error("core reset stuck");
   AST_RST_RISE:
      assert property ($rose(core_reset) |-> run >= 5'h0C)
      else $error("core reset from short pulse");
   AST_RST_BANK:
      assert property (core_reset[*3] |-> bank_base == 5'h00)
      else $error("bank not cleared in reset");
   AST_RST_PORT:
      assert property (core_reset[*2] |-> mux_port_pins_oe_n == 8'hFF)
      else $error("port driven in reset");
   AST_SLVERR:
      assert property (pready |-> pslverr == !(paddr inside {8'h00,
         8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28,
         8'hD0, 8'hE0}))
      else $error("wrong error response");
   AST_UPPER:
      assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("read data above 16 bits");
endmodule
bind cpu_status_fetch cpu_status_chk u_chk (.pclk, .presetn, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch_source_select,
   .reset_pin,
   .mux_port_pins_oe_n, .fetch_internal, .bank_base, .core_reset);
`default_nettype wire

// file: ext_mem_model.sv
// external memory on the multiplexed low address/data port
// assumes split pin ports; resolves the level seen on each pin
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input  wire logic       pclk,
   input  wire logic       pull_en,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   output logic      [7:0] pin_level
);
   logic [7:0] addr = 8'h00;
   logic [7:0] last = 8'h00;
   logic [3:0] hold = 4'h0;
   logic [7:0] idle;
   always @(posedge pclk)
   begin
      last <= pin_level;
      if (pin_oe_n == 8'h00)
      begin
         addr <= pin_out;
         hold <= 4'h8;
      end
      else if (hold != 4'h0)
         hold <= hold - 4'h1;
   end
   // without pullups a released line has no stable level
   assign idle = pull_en ? 8'hFF : ~last;
   // answers only after an address phase, only on a free bus
   assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n &
      ((hold != 4'h0 && pin_oe_n == 8'hFF) ? addr ^ 8'h5A : idle));
endmodule
`default_nettype wire

// file: cpu_status_and_fetch_select_tb.sv
// self-checking bench for the status word and fetch select block
// assumes the bound checker and the external memory model
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_fetch_select_tb;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [15:0] v;
      logic        e;
      logic        sel;
      logic [4:0]  bk;
   } row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        fetch_source_select = 1'b1;
   logic        reset_pin = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pins_in;
   logic [7:0]  pins_out;
   logic [7:0]  pins_oe_n;
   logic [4:0]  bank_base;
   logic        core_reset;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   row_t        rows [0:38] = '{
   '{0,8'hD0,16'h00,0,1,5'h00}, '{1,8'hD0,16'h08,0,1,5'h08},
   '{1,8'hD0,16'hFE,0,1,5'h18}, '{0,8'hD0,16'hFE,0,1,5'h18},
   '{1,8'hE0,16'h07,0,1,5'h18}, '{0,8'hD0,16'hFF,0,1,5'h18},
   '{1,8'hD0,16'h10,0,1,5'h10}, '{0,8'hD0,16'h11,0,1,5'h10},
   '{1,8'h00,16'hF901,0,1,5'h10}, '{0,8'hD0,16'hD0,0,1,5'h10},
   '{1,8'hE0,16'h7F,0,1,5'h10}, '{1,8'h00,16'h0101,0,1,5'h10},
   '{0,8'hD0,16'h55,0,1,5'h10}, '{0,8'h20,16'h00,1,1,5'h10},
   '{1,8'hFC,16'hFF,1,1,5'h10}, '{0,8'h04,16'h06,0,1,5'h10},
   '{1,8'h18,16'h4000,0,1,5'h10}, '{0,8'h04,16'h02,0,1,5'h10},
   '{1,8'h18,16'h3FFF,0,1,5'h10}, '{0,8'h04,16'h06,0,1,5'h10},
   '{0,8'h04,16'h00,0,0,5'h10}, '{0,8'h14,16'hFF,0,1,5'h10},
   '{1,8'h10,16'h0F,0,1,5'h10}, '{0,8'h14,16'h0F,0,1,5'h10},
   '{1,8'h10,16'hFF,0,1,5'h10}, '{1,8'h18,16'h0033,0,1,5'h10},
   '{1,8'h08,16'h01,0,1,5'h10}, '{0,8'h0C,16'h69,0,1,5'h10},
   '{0,8'h18,16'h34,0,1,5'h10}, '{1,8'h24,16'h1A,0,1,5'h10},
   '{1,8'h28,16'h3C,0,1,5'h10}, '{0,8'h28,16'h3C,0,1,5'h10},
   '{0,8'h24,16'h1A,0,1,5'h10}, '{1,8'h0C,16'hA5,0,1,5'h10},
   '{1,8'h08,16'h07,0,1,5'h10}, '{0,8'h18,16'h34,0,1,5'h10},
   '{1,8'h08,16'h09,0,1,5'h10}, '{0,8'h0C,16'hA5,0,1,5'h10},
   '{0,8'h18,16'h35,0,1,5'h10}};
   cpu_status_fetch #(.LARGE_VARIANT(0)) dut (.pclk, .presetn,
      .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fetch_source_select, .reset_pin,
      .mux_port_pins_in(pins_in), .mux_port_pins_out(pins_out),
      .mux_port_pins_oe_n(pins_oe_n), .fetch_internal(), .bank_base,
      .core_reset);
   ext_mem_model mem (.pclk, .pull_en(1'b1), .pin_out(pins_out),
      .pin_oe_n(pins_oe_n), .pin_level(pins_in));
   task automatic stop_test;
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always #10 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         num_errors++;
         stop_test;
      end
   end
   initial
   begin
      logic [31:0] r;
      logic        e;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         fetch_source_select <= rows[i].sel;
         repeat (4) @(posedge pclk);
         apb(rows[i].w, rows[i].a, {16'h0000, rows[i].v}, r, e);
         repeat (4) @(posedge pclk);
         if (!rows[i].w)
            check(r, {16'h0000, rows[i].v});
         check({31'h0, e}, {31'h0, rows[i].e});
         check({27'h0, bank_base}, {27'h0, rows[i].bk});
      end
      reset_pin <= 1'b1;
      repeat (20) @(posedge pclk);
      check({31'h0, core_reset}, 32'h1);
      check({27'h0, bank_base}, 32'h0);
      reset_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      check({31'h0, core_reset}, 32'h0);
      apb(1'b0, 8'hD0, 32'h0, r, e);
      check(r, 32'h0);
      stop_test;
   end
endmodule
`default_nettype wire
